// File: common/acc_if.sv
// Connection between the converter device end and its controlling end.
// The bench instantiates it once and joins both ends to it.
`timescale 1ns/1ps
`default_nettype none
interface acc_if;
   import acc_pkg::*;
   logic [DECW-1:0] decim_factor;
   logic foreground_cal_trigger;
   logic background_cal_select;
   logic continuous_cal_enable;
   logic reduced_signal_cal_option;
   logic timing_cal_enable;
   logic test_pattern_enable;
   logic [SW-1:0] offset_adjust;
   logic serial_link_enable;
   logic cal_busy;
   logic bg_active;
   logic [2:0] offline_core;
   logic [LANES*SW-1:0] lane_data;
   logic [IQW-1:0] iq_i;
   logic [IQW-1:0] iq_q;
   logic data_valid;
   logic data_iq;
   modport dev (
      input decim_factor, foreground_cal_trigger, background_cal_select,
      input continuous_cal_enable, reduced_signal_cal_option,
      input timing_cal_enable, test_pattern_enable, offset_adjust,
      input serial_link_enable,
      output cal_busy, bg_active, offline_core, lane_data, iq_i, iq_q,
      output data_valid, data_iq);
   modport ctl (
      output decim_factor, foreground_cal_trigger, background_cal_select,
      output continuous_cal_enable, reduced_signal_cal_option,
      output timing_cal_enable, test_pattern_enable, offset_adjust,
      output serial_link_enable,
      input cal_busy, bg_active, offline_core, lane_data, iq_i, iq_q,
      input data_valid, data_iq);
endinterface
`default_nettype wire

// File: common/acc_pkg.sv
// Shared constants for the converter calibration and test-pattern control.
// Assumes one sample clock; both ends and the bench import this package.
package acc_pkg;
   localparam int LANES = 8;
   localparam int SW = 12;
   localparam int IQW = 15;
   localparam int DECW = 6;
   localparam int CORES = 5;
   localparam int HALF = 4;
   localparam logic [DECW-1:0] DEC_BYPASS = 6'h01;
   localparam logic [DECW-1:0] DEC_4 = 6'h04;
   localparam logic [DECW-1:0] DEC_8 = 6'h08;
   localparam logic [DECW-1:0] DEC_10 = 6'h0a;
   localparam logic [DECW-1:0] DEC_16 = 6'h10;
   localparam logic [DECW-1:0] DEC_20 = 6'h14;
   localparam logic [DECW-1:0] DEC_32 = 6'h20;
   localparam logic [SW-1:0] STATIC_CODE = 12'h800;
   // Initial calibration length in sample-clock cycles, index {bg,timing,low}
   localparam int unsigned FG_CYC_DEF [8] = '{
      32'd102000000, 32'd64000000, 32'd227000000, 32'd189000000,
      32'd127500000, 32'd80000000, 32'd283750000, 32'd236250000};
   localparam int unsigned BG_CYC_FULL_DEF = 32'd816000000;
   localparam int unsigned BG_CYC_LOW_DEF = 32'd512000000;
   localparam logic [2:0] OFFLINE_RESET = 3'h4;
   // Per-bank low pattern word, [lane half][bank]
   localparam logic [SW-1:0] BANK_LO [2][CORES] = '{
      '{12'h000, 12'h008, 12'h010, 12'h020, 12'h004},
      '{12'h040, 12'h100, 12'h200, 12'h400, 12'h080}};
   // Controller register map (byte addresses) and bit positions
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_DECIM = 8'h04;
   localparam logic [7:0] REG_OFFSET = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_EXP_DT = 8'h10;
   localparam int CTL_TRIG = 0;
   localparam int CTL_BG = 1;
   localparam int CTL_LOW = 2;
   localparam int CTL_TIME = 3;
   localparam int CTL_TP = 4;
   localparam int CTL_LINK = 5;
   localparam int ST_BUSY = 0;
   localparam int ST_BGACT = 1;
   localparam int ST_OFF = 2;
   localparam int ST_HOLD = 5;
   localparam int ST_ADV = 6;
   localparam logic [DECW-1:0] DECIM_RESET = 6'h01;
   localparam logic signed [8:0] TEMP_LIMIT = 9'sd20;
   localparam logic [7:0] BG_ADVISE_DT = 8'h1e;
endpackage

// File: core/acc_cal.sv
// Calibration sequencer: foreground run, then background core rotation.
// Assumes cal_rst_n is the device reset combined with the trigger bit.
`timescale 1ns/1ps
`default_nettype none
module acc_cal
   import acc_pkg::*;
#(
   parameter int unsigned FG_CYC [8] = FG_CYC_DEF,
   parameter int unsigned BG_CYC_FULL = BG_CYC_FULL_DEF,
   parameter int unsigned BG_CYC_LOW = BG_CYC_LOW_DEF
) (
   input wire logic ref_clk,
   input wire logic cal_rst_n,
   input wire logic start,
   input wire logic bg_en,
   input wire logic timing_en,
   input wire logic low_sig,
   output logic busy,
   output logic bg_active,
   output logic [2:0] offline_core
);
   localparam logic [31:0] DWELL_FULL = 32'(BG_CYC_FULL / CORES);
   localparam logic [31:0] DWELL_LOW = 32'(BG_CYC_LOW / CORES);
   localparam logic [2:0] LAST_CORE = 3'(CORES - 1);

   typedef enum logic [1:0] {CS_IDLE, CS_FG, CS_BG} acc_cal_e;
   typedef struct packed {
      acc_cal_e st;
      logic [31:0] cnt;
      logic [31:0] dwell;
      logic bg;
      logic busy;
      logic bga;
      logic [2:0] off;
   } acc_cal_s;

   acc_cal_s cal_reg, cal_next;

   always_comb begin
      cal_next = cal_reg;
      case (cal_reg.st)
         CS_IDLE: begin
            if (start) begin
               // Length picked from the settings at start
               cal_next.cnt =
                  32'(FG_CYC[{bg_en, timing_en, low_sig}]) - 32'h1; // RL5 RL16
               cal_next.dwell = low_sig ? DWELL_LOW : DWELL_FULL; // RL10
               cal_next.bg = bg_en;
               cal_next.busy = 1'b1; // RL21
               cal_next.st = CS_FG;
            end
         end
         CS_FG: begin
            if (cal_reg.cnt == 32'h0) begin
               cal_next.busy = 1'b0; // RL21
               if (cal_reg.bg) begin
                  cal_next.st = CS_BG; // RL12
                  cal_next.bga = 1'b1; // RL9
                  cal_next.cnt = cal_reg.dwell - 32'h1;
               end else begin
                  cal_next.st = CS_IDLE;
               end
            end else begin
               cal_next.cnt = cal_reg.cnt - 32'h1;
            end
         end
         CS_BG: begin
            if (!bg_en) begin
               cal_next.st = CS_IDLE;
               cal_next.bga = 1'b0;
               cal_next.off = OFFLINE_RESET;
            end else if (cal_reg.cnt == 32'h0) begin
               // Fixed rate; one core swaps out as the next goes off-line
               cal_next.cnt = cal_reg.dwell - 32'h1; // RL10
               cal_next.off = (cal_reg.off == LAST_CORE) ? 3'h0
                  : cal_reg.off + 3'h1; // RL9
            end else begin
               cal_next.cnt = cal_reg.cnt - 32'h1;
            end
         end
         default: cal_next.st = CS_IDLE;
      endcase
   end

   // The trigger resets this logic asynchronously, as the device does
   always_ff @(posedge ref_clk or negedge cal_rst_n) begin // RL6
      if (!cal_rst_n) begin
         cal_reg <= '{st: CS_IDLE, cnt: 32'h0, dwell: 32'h0, bg: 1'b0,
            busy: 1'b0, bga: 1'b0, off: OFFLINE_RESET};
      end else begin
         cal_reg <= cal_next;
      end
   end

   assign busy = cal_reg.busy;
   assign bg_active = cal_reg.bga;
   assign offline_core = cal_reg.off;
endmodule // acc_cal
`default_nettype wire

// File: core/acc_ctl.sv
// Controlling end: Wishbone classic registers driving the device settings.
// Assumes a single-master Wishbone bus and a temperature reading in degrees.
`timescale 1ns/1ps
`default_nettype none
module acc_ctl
   import acc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic signed [7:0] temp_c,
   acc_if.ctl lnk
);
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      logic trig;
      logic bg;
      logic low;
      logic tim;
      logic tp;
      logic link_en;
      logic hold;
      logic seen;
      logic lnk_out;
      logic calibrated;
      logic [DECW-1:0] decim;
      logic [SW-1:0] ofs;
      logic [7:0] exp_dt;
      logic signed [7:0] cal_temp;
   } acc_ctl_s;

   acc_ctl_s ctl_reg, ctl_next;

   always_comb begin
      logic wr;
      logic signed [8:0] dt;
      logic drift;
      wr = 1'b0;
      dt = '0;
      drift = 1'b0;
      ctl_next = ctl_reg;
      ctl_next.trig = 1'b0;
      ctl_next.ack = wb_cyc_i & wb_stb_i & ~ctl_reg.ack;
      if (wb_cyc_i && wb_stb_i && !ctl_reg.ack) begin
         ctl_next.dat = '0;
         case (wb_adr_i)
            REG_CTRL: ctl_next.dat[CTL_LINK:CTL_BG] = {ctl_reg.link_en,
               ctl_reg.tp, ctl_reg.tim, ctl_reg.low, ctl_reg.bg};
            REG_DECIM: ctl_next.dat[DECW-1:0] = ctl_reg.decim;
            REG_OFFSET: ctl_next.dat[SW-1:0] = ctl_reg.ofs;
            REG_STATUS: ctl_next.dat[ST_ADV:ST_BUSY] = {
               ctl_reg.exp_dt > BG_ADVISE_DT, ctl_reg.hold, lnk.offline_core,
               lnk.bg_active, lnk.cal_busy}; // RL14
            REG_EXP_DT: ctl_next.dat[7:0] = ctl_reg.exp_dt;
            default: ctl_next.dat = '0;
         endcase
      end
      // Writes land on the edge where the master sees ack
      wr = wb_cyc_i & wb_stb_i & wb_we_i & ctl_reg.ack & wb_sel_i[0];
      if (wr) begin
         case (wb_adr_i)
            REG_CTRL: begin
               ctl_next.trig = wb_dat_i[CTL_TRIG]; // RL4
               ctl_next.bg = wb_dat_i[CTL_BG];
               ctl_next.low = wb_dat_i[CTL_LOW];
               ctl_next.tim = wb_dat_i[CTL_TIME]; // RL15
               ctl_next.tp = wb_dat_i[CTL_TP];
               ctl_next.link_en = wb_dat_i[CTL_LINK];
               // Entering background mode needs one foreground run
               if (wb_dat_i[CTL_BG] && !ctl_reg.bg) begin
                  ctl_next.trig = 1'b1; // RL12
               end
            end
            REG_DECIM: ctl_next.decim = wb_dat_i[DECW-1:0];
            REG_OFFSET: begin
               ctl_next.ofs[7:0] = wb_dat_i[7:0];
               if (wb_sel_i[1]) begin
                  ctl_next.ofs[SW-1:8] = wb_dat_i[SW-1:8];
               end
            end
            REG_EXP_DT: ctl_next.exp_dt = wb_dat_i[7:0];
            default: ctl_next.dat = ctl_reg.dat;
         endcase
      end
      dt = 9'(temp_c) - 9'(ctl_reg.cal_temp);
      drift = (dt > TEMP_LIMIT) || (dt < -TEMP_LIMIT);
      if (drift && ctl_reg.calibrated && !ctl_reg.bg && !ctl_reg.hold) begin
         ctl_next.trig = 1'b1; // RL8
      end
      if (ctl_next.trig) begin
         // Calibration glitches device clocks, so the link is restarted
         ctl_next.hold = 1'b1; // RL7
         ctl_next.seen = 1'b0;
         ctl_next.cal_temp = temp_c; // RL8
         ctl_next.calibrated = 1'b1;
      end else if (ctl_reg.hold && !ctl_reg.trig && lnk.cal_busy) begin
         // Busy of a run that this trigger cuts short must not count
         ctl_next.seen = 1'b1;
      end else if (ctl_reg.hold && ctl_reg.seen) begin
         ctl_next.hold = 1'b0; // RL7
         ctl_next.seen = 1'b0;
      end
      ctl_next.lnk_out = ctl_next.link_en & ~ctl_next.hold; // RL7
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_reg <= '0;
         ctl_reg.decim <= DECIM_RESET;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   assign wb_dat_o = ctl_reg.dat;
   assign wb_ack_o = ctl_reg.ack;
   assign lnk.decim_factor = ctl_reg.decim;
   assign lnk.foreground_cal_trigger = ctl_reg.trig;
   assign lnk.background_cal_select = ctl_reg.bg; // RL11
   assign lnk.continuous_cal_enable = ctl_reg.bg; // RL11
   assign lnk.reduced_signal_cal_option = ctl_reg.low;
   assign lnk.timing_cal_enable = ctl_reg.tim;
   assign lnk.test_pattern_enable = ctl_reg.tp;
   assign lnk.offset_adjust = ctl_reg.ofs;
   assign lnk.serial_link_enable = ctl_reg.lnk_out;
endmodule // acc_ctl
`default_nettype wire

// File: core/acc_dev.sv
// Converter device end: output mode, calibration control, lane test pattern.
// Assumes raw lane samples and DDC words arrive every sample clock.
// Notes on behaviour
// RL1: Decimation one outputs raw 12-bit samples, full rate
// RL2: Larger decimation outputs I/Q at reduced rate; the code does so only for 4, 8, 10, 16, 20 and 32
// RL3: Foreground calibration forces a static output code
// RL4: Foreground trigger starts calibration, clears itself
// RL5: Calibration length depends on the option settings
// RL6: Trigger asynchronously resets calibration control logic
// RL7: Controller cycles serial link enable after trigger
// RL8: Controller recalibrates after 20 degree temperature drift
// RL9: Background mode rotates one off-line core of five
// RL10: Background cycle fixed: 816 or 512 million cycles
// RL11: Background needs select and continuous bits both set
// RL12: Background starts after one foreground calibration
// RL13: Offset adjust ignored while background mode enabled
// RL14: Background advised above 30 degrees expected change
// RL15: Timing calibration off at reset, runs per trigger
// RL16: Timing calibration lengthens the foreground calibration
// RL17: Calibration uses no external stimulus
// RL18: Test pattern replaces samples, repeats every two frames
// RL19: Lane pattern alternates low word and its complement
// RL20: Background mode pattern follows the routed bank
// RL21: Busy flag held from trigger until count ends
`timescale 1ns/1ps
`default_nettype none
module acc_dev
   import acc_pkg::*;
#(
   parameter int unsigned FG_CYC [8] = FG_CYC_DEF,
   parameter int unsigned BG_CYC_FULL = BG_CYC_FULL_DEF,
   parameter int unsigned BG_CYC_LOW = BG_CYC_LOW_DEF
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   acc_if.dev lnk,
   input wire logic [LANES*SW-1:0] adc_samples,
   input wire logic [IQW-1:0] ddc_i,
   input wire logic [IQW-1:0] ddc_q
);
   typedef struct packed {
      logic trig;
      logic start;
      logic [DECW-1:0] dcnt;
      logic tp_phase;
      logic [LANES*SW-1:0] lanes;
      logic [IQW-1:0] iq_i;
      logic [IQW-1:0] iq_q;
      logic valid;
      logic iq;
   } acc_dev_s;

   acc_dev_s dev_reg, dev_next;
   logic cal_rst_n;
   logic cal_busy;
   logic cal_bga;
   logic [2:0] cal_off;
   logic bg_en;

   // Both bits are needed before the device treats background as enabled
   assign bg_en = lnk.background_cal_select
      & lnk.continuous_cal_enable; // RL11
   // Calibration state is wiped while the trigger bit stands
   assign cal_rst_n = rst_n & ~dev_reg.trig; // RL6

   // Fed only from internal state and the link settings: no outside stimulus is involved
   acc_cal #(
      .FG_CYC(FG_CYC),
      .BG_CYC_FULL(BG_CYC_FULL),
      .BG_CYC_LOW(BG_CYC_LOW)
   ) u_cal (
      .ref_clk(ref_clk),
      .cal_rst_n(cal_rst_n),
      .start(dev_reg.start), // RL17
      .bg_en(bg_en),
      .timing_en(lnk.timing_cal_enable), // RL15
      .low_sig(lnk.reduced_signal_cal_option),
      .busy(cal_busy),
      .bg_active(cal_bga),
      .offline_core(cal_off)
   );

   always_comb begin
      logic bypass;
      logic ddc_ok;
      logic strobe;
      logic [SW-1:0] ofs;
      logic [SW-1:0] lo;
      logic [2:0] pos;
      logic [2:0] bank;
      bypass = 1'b0;
      ddc_ok = 1'b0;
      strobe = 1'b0;
      ofs = '0;
      lo = '0;
      pos = '0;
      bank = '0;
      dev_next = dev_reg;
      // Set for one cycle at a time; a trigger the far side holds high pulses every other cycle
      dev_next.trig = lnk.foreground_cal_trigger & ~dev_reg.trig; // RL4
      dev_next.start = dev_reg.trig; // RL4
      bypass = (lnk.decim_factor == DEC_BYPASS);
      case (lnk.decim_factor)
         DEC_4, DEC_8, DEC_10, DEC_16, DEC_20, DEC_32: ddc_ok = 1'b1; // RL2
         default: ddc_ok = 1'b0;
      endcase
      if (!ddc_ok || dev_reg.dcnt >= lnk.decim_factor - 6'h1) begin
         dev_next.dcnt = '0;
      end else begin
         dev_next.dcnt = dev_reg.dcnt + 6'h1;
      end
      strobe = ddc_ok && (dev_reg.dcnt == '0);
      dev_next.tp_phase = ~dev_reg.tp_phase; // RL18
      // Offset trim is not applied while background mode runs
      ofs = bg_en ? '0 : lnk.offset_adjust; // RL13
      dev_next.iq = 1'b0;
      dev_next.valid = 1'b0;
      if (cal_busy) begin
         // No conversion data during foreground calibration
         for (int l = 0; l < LANES; l++) begin
            dev_next.lanes[l*SW +: SW] = STATIC_CODE; // RL3
         end
         dev_next.iq_i = '0;
         dev_next.iq_q = '0;
         dev_next.valid = lnk.serial_link_enable;
      end else if (bypass) begin
         for (int l = 0; l < LANES; l++) begin
            pos = 3'(l % HALF);
            // Lanes skip the off-line core, so banks shift past it
            bank = (cal_bga && pos >= cal_off) ? pos + 3'h1 : pos; // RL20
            lo = BANK_LO[l / HALF][bank]; // RL19
            if (lnk.test_pattern_enable) begin
               dev_next.lanes[l*SW +: SW] =
                  dev_reg.tp_phase ? ~lo : lo; // RL18 RL19
            end else begin
               dev_next.lanes[l*SW +: SW] =
                  adc_samples[l*SW +: SW] + ofs; // RL1
            end
         end
         dev_next.valid = lnk.serial_link_enable; // RL1
      end else if (strobe) begin
         dev_next.iq_i = ddc_i; // RL2
         dev_next.iq_q = ddc_q; // RL2
         dev_next.iq = 1'b1;
         dev_next.valid = lnk.serial_link_enable;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dev_reg <= '0;
      end else begin
         dev_reg <= dev_next;
      end
   end

   assign lnk.cal_busy = cal_busy;
   assign lnk.bg_active = cal_bga;
   assign lnk.offline_core = cal_off;
   assign lnk.lane_data = dev_reg.lanes;
   assign lnk.iq_i = dev_reg.iq_i;
   assign lnk.iq_q = dev_reg.iq_q;
   assign lnk.data_valid = dev_reg.valid;
   assign lnk.data_iq = dev_reg.iq;
endmodule // acc_dev
`default_nettype wire

// File: sim/acc_assertions.sv
// Checker on the link between device end and controlling end.
// Assumes the bench wires it to the interface and passes the same counts.
`timescale 1ns/1ps
`default_nettype none
module acc_assertions
   import acc_pkg::*;
#(
   parameter int unsigned FG_CYC [8] = FG_CYC_DEF
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [DECW-1:0] decim_factor,
   input wire logic foreground_cal_trigger,
   input wire logic background_cal_select,
   input wire logic reduced_signal_cal_option,
   input wire logic timing_cal_enable,
   input wire logic test_pattern_enable,
   input wire logic serial_link_enable,
   input wire logic cal_busy,
   input wire logic bg_active,
   input wire logic [2:0] offline_core,
   input wire logic [LANES*SW-1:0] lane_data,
   input wire logic data_valid,
   input wire logic data_iq
);
   logic [31:0] busy_len;
   int unsigned fg_len;
   assign fg_len = FG_CYC[{background_cal_select, timing_cal_enable,
      reduced_signal_cal_option}];
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_len <= 32'h0;
      end else begin
         busy_len <= cal_busy ? busy_len + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   trig_clear_a: assert property (foreground_cal_trigger |=>
      !foreground_cal_trigger) else $error("trigger not cleared");
   trig_busy_a: assert property (foreground_cal_trigger |->
      ##[1:4] cal_busy) else $error("busy did not follow trigger");
   // One cycle of slack either way on where the count is taken
   // A retrigger cuts a run short through the asynchronous reset
   busy_len_a: assert property ($fell(cal_busy) &&
      !$past(foreground_cal_trigger) |->
      busy_len + 1 >= fg_len && busy_len <= fg_len + 1)
      else $error("calibration length wrong");
   // Lanes follow busy one cycle late through the output register
   static_code_a: assert property ($past(cal_busy) |->
      lane_data == {LANES{STATIC_CODE}}) else $error("output not static");
   link_off_a: assert property (cal_busy |->
      !serial_link_enable && !data_valid) else $error("link on in cal");
   link_drop_a: assert property (foreground_cal_trigger |->
      !serial_link_enable) else $error("link kept on at trigger");
   bg_start_a: assert property ($fell(cal_busy) &&
      !$past(foreground_cal_trigger) && background_cal_select |->
      bg_active) else $error("no background");
   core_step_a: assert property (bg_active && $changed(offline_core) |->
      offline_core == ($past(offline_core) == 3'h4 ? 3'h0 :
      $past(offline_core) + 3'h1)) else $error("bad core order");
   core_hold_a: assert property (bg_active && $changed(offline_core) |=>
      $stable(offline_core) [*8]) else $error("core swap too fast");
   pattern_a: assert property ($past(test_pattern_enable) &&
      $past(test_pattern_enable, 2) && $past(decim_factor) == DEC_BYPASS &&
      $past(decim_factor, 2) == DEC_BYPASS && !$past(cal_busy) &&
      !$past(cal_busy, 2) && !$past(bg_active) && !$past(bg_active, 2)
      |-> lane_data == ~$past(lane_data)) else $error("pattern wrong");
   bypass_a: assert property (data_valid && decim_factor == DEC_BYPASS &&
      $past(decim_factor) == DEC_BYPASS |-> !data_iq)
      else $error("iq words in bypass");
   ddc_rate_a: assert property (data_valid && data_iq |=>
      !(data_valid && data_iq) [*3]) else $error("iq rate too high");
endmodule // acc_assertions
`default_nettype wire

// File: sim/tb.sv
// Bench joining device end and controller through the link interface.
// Assumes short calibration counts so the whole run stays brief.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import acc_pkg::*;
   localparam int unsigned FG [8] = '{20, 14, 34, 28, 24, 16, 40, 32};
   localparam logic [DECW-1:0] DECS [6] = '{DEC_4, DEC_8, DEC_10,
      DEC_16, DEC_20, DEC_32};
   logic ref_clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel, wb_be;
   logic [31:0] wb_wd, wb_rd, rd;
   logic signed [7:0] temp_c;
   logic [LANES*SW-1:0] adc;
   logic [IQW-1:0] ddc_i, ddc_q;
   int err_count, num_checks, n, e;
   acc_if lnk ();
   acc_dev #(.FG_CYC(FG), .BG_CYC_FULL(50), .BG_CYC_LOW(25)) i_acc_dev (
      .ref_clk(ref_clk), .rst_n(rst_n), .lnk(lnk), .adc_samples(adc),
      .ddc_i(ddc_i), .ddc_q(ddc_q));
   acc_ctl i_acc_ctl (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd),
      .wb_ack_o(wb_ack), .temp_c(temp_c), .lnk(lnk));
   acc_assertions #(.FG_CYC(FG)) i_acc_assertions (.ref_clk(ref_clk),
      .rst_n(rst_n), .decim_factor(lnk.decim_factor),
      .foreground_cal_trigger(lnk.foreground_cal_trigger),
      .background_cal_select(lnk.background_cal_select),
      .reduced_signal_cal_option(lnk.reduced_signal_cal_option),
      .timing_cal_enable(lnk.timing_cal_enable),
      .test_pattern_enable(lnk.test_pattern_enable),
      .serial_link_enable(lnk.serial_link_enable),
      .cal_busy(lnk.cal_busy), .bg_active(lnk.bg_active),
      .offline_core(lnk.offline_core), .lane_data(lnk.lane_data),
      .data_valid(lnk.data_valid), .data_iq(lnk.data_iq));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask
   // Classic cycle: hold everything until ack is sampled, then release
   task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge ref_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_wd <= d;
      wb_sel <= wb_be;
      do begin
         @(posedge ref_clk);
         k++;
      end while (wb_ack !== 1'b1 && k < 40);
      rd = wb_rd;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (k >= 40) chk("bus ack", 1, 0);
   endtask
   task automatic wait_busy(input logic lvl);
      int k;
      k = 0;
      while (lnk.cal_busy !== lvl && k < 200) begin
         @(posedge ref_clk);
         k++;
      end
      chk("cal busy", lvl, lnk.cal_busy);
   endtask
   task automatic wait_core0();
      int k;
      for (k = 0; k < 100 && lnk.offline_core !== 3'h0; k++) begin
         @(posedge ref_clk);
      end
      repeat (2) @(posedge ref_clk);
   endtask
   function automatic logic [SW-1:0] lane(input int l);
      return lnk.lane_data[SW*l+:SW];
   endfunction
   // Either phase of the pattern is accepted; alternation is asserted outside background mode
   task automatic chk_tp(input int sh);
      logic [SW-1:0] lo;
      for (int l = 0; l < LANES; l++) begin
         lo = BANK_LO[l/HALF][l%HALF + sh];
         chk("lane pattern", lo, lane(l) === ~lo ? lo : lane(l));
      end
   endtask
   initial begin
      rst_n = 1'b0;
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_wd} = '0;
      wb_sel = 4'hf;
      wb_be = 4'hf;
      temp_c = 8'sd0;
      adc = 96'h777666555444333222111000;
      ddc_i = 15'h1234;
      ddc_q = 15'h0567;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      wb(0, REG_STATUS, 0);
      chk("status", 32'h10, rd);
      wb(0, REG_CTRL, 0);
      chk("ctrl", 32'h0, rd);
      chk("timing enable", 0, lnk.timing_cal_enable);
      wb(0, REG_DECIM, 0);
      chk("decim", 32'h1, rd);
      wb(1, 8'h14, 32'hff);
      wb(0, 8'h14, 0);
      chk("unmapped", 32'h0, rd);
      wb(1, REG_EXP_DT, 32'h1f);
      wb(0, REG_STATUS, 0);
      chk("advice", 32'h50, rd);
      wb(1, REG_EXP_DT, 32'h1e);
      wb(0, REG_STATUS, 0);
      chk("advice", 32'h10, rd);
      wb_be = 4'h1;
      wb(1, REG_OFFSET, 32'hf05);
      wb_be = 4'h0;
      wb(1, REG_OFFSET, 32'h7);
      wb_be = 4'hf;
      wb(0, REG_OFFSET, 0);
      chk("offset bytes", 32'h5, rd);
      $display("test reset done");
      wb(1, REG_OFFSET, 32'h3);
      wb(1, REG_CTRL, 32'h20);
      repeat (4) @(posedge ref_clk);
      for (int l = 0; l < LANES; l++)
         chk("raw", adc[SW*l+:SW] + 3, lane(l));
      chk("valid", 1, lnk.data_valid);
      wb(1, REG_CTRL, 32'h30);
      repeat (4) @(posedge ref_clk);
      chk_tp(0);
      $display("test bypass done");
      for (int s = 0; s < 4; s++) begin
         wb(1, REG_CTRL, 32'h21 | (s[1] ? 32'h8 : 0) | (s[0] ? 32'h4 : 0));
         wait_busy(1);
         wb(0, REG_STATUS, 0);
         chk("busy bit", 1, rd[0]);
         if (s == 0) begin
            wb(1, REG_CTRL, 32'h21);
            wait_busy(0);
            wait_busy(1);
         end
         wait_busy(0);
         repeat (4) @(posedge ref_clk);
         chk("link back", 1, lnk.serial_link_enable);
      end
      temp_c <= 8'sd21;
      wait_busy(1);
      wait_busy(0);
      temp_c <= 8'sd41;
      repeat (10) @(posedge ref_clk);
      chk("no recal", 0, lnk.cal_busy);
      temp_c <= 8'sd42;
      wait_busy(1);
      wait_busy(0);
      $display("test calibration done");
      wb(1, REG_CTRL, 32'h20);
      foreach (DECS[j]) begin
         wb(1, REG_DECIM, DECS[j]);
         repeat (3) @(posedge ref_clk);
         n = 0;
         e = 160 / DECS[j];
         repeat (160) begin
            @(posedge ref_clk);
            if (lnk.data_valid === 1'b1 && lnk.data_iq === 1'b1) begin
               n++;
               chk("iq word", ddc_i, lnk.iq_i);
               chk("iq q word", ddc_q, lnk.iq_q);
            end
         end
         chk("iq rate", e, n);
      end
      wb(1, REG_DECIM, 32'h2);
      repeat (3) @(posedge ref_clk);
      chk("bad decim", 0, lnk.data_valid);
      wb(1, REG_DECIM, 32'h1);
      $display("test ddc done");
      wb(1, REG_CTRL, 32'h22);
      wait_busy(1);
      wait_busy(0);
      chk("bg active", 1, lnk.bg_active);
      chk("bg bits", 3, {lnk.background_cal_select,
         lnk.continuous_cal_enable});
      wait_core0();
      for (int l = 0; l < LANES; l++)
         chk("no offset", adc[SW*l+:SW], lane(l));
      chk("bg valid", 1, lnk.data_valid);
      wb(1, REG_CTRL, 32'h32);
      repeat (12) @(posedge ref_clk);
      wait_core0();
      chk_tp(1);
      $display("test background done");
      test_done();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      $display("watchdog expired");
      test_done();
   end
endmodule // tb
`default_nettype wire
